// [src/sched_pkg.sv]
package sched_pkg;
  // ==================================================
  // timing
  localparam int CLK_KHZ = 250000;
  localparam int SLOT_MS = 400;
  localparam int ACTIVE_MS = 384;
  localparam int GUARD_MS = 16;
  localparam int SLOT_CYC = SLOT_MS * CLK_KHZ;
  localparam int ACTIVE_CYC = ACTIVE_MS * CLK_KHZ;
  localparam int GUARD_CYC = GUARD_MS * CLK_KHZ;
  // ==================================================
  // frame structure
  localparam int SLOTS_PER_FRAME = 60;
  localparam int FRAMES_PER_SUPER = 64;
  localparam logic [5:0] LAST_SLOT = 6'h3b;
  localparam logic [5:0] LAST_FRAME = 6'h3f;
  localparam logic [5:0] RELAY_START = 6'h13;
  localparam logic [5:0] RESERVED_SLOT = 6'h37;
  localparam logic [5:0] MAIN_SYNC = 6'h01;
  localparam logic [5:0] RELAY_SYNC = 6'h01;
  localparam logic [5:0] RELAY_UL = 6'h05;
  localparam logic [3:0] MAIN_FMT_CNT = 4'h8;
  localparam logic [3:0] RELAY_FMT_CNT = 4'h5;
  // frame offset codes and their slot delays
  localparam logic [1:0] OFS_NONE = 2'h0;
  localparam logic [1:0] OFS_20 = 2'h1;
  localparam logic [1:0] OFS_40 = 2'h2;
  localparam logic [5:0] OFS_20_SLOTS = 6'h14;
  localparam logic [5:0] OFS_40_SLOTS = 6'h28;
  // battery classes
  localparam logic [1:0] CLS_NONE = 2'h0;
  localparam logic [1:0] CLS_LISTEN = 2'h1;
  localparam logic [1:0] CLS_PERIODIC = 2'h2;
  localparam logic [1:0] CLS_DORMANT = 2'h3;
  // ==================================================
  // types
  typedef enum logic [2:0] {
    SF_NONE = 3'h0, SF_DL = 3'h1, SF_NOISE = 3'h2, SF_ULD = 3'h3,
    SF_ULA = 3'h4, SF_RDL = 3'h5, SF_RUL = 3'h6
  } sub_t;
  typedef enum logic [1:0] {
    ST_AWAKE = 2'h0, ST_SLEEP = 2'h1, ST_RESYNC = 2'h2, ST_HOLD = 2'h3
  } pwr_t;
  typedef struct packed {
    sub_t main_sf;
    sub_t relay_sf;
    logic main_ok;
    logic relay_ok;
    logic main_first;
    logic relay_first;
    logic reserved;
  } sf_info_t;
  typedef struct packed {
    sub_t sf;
    logic [7:0] units;
  } txreq_t;
  // ==================================================
  // other-dl, noise, ul data, ul ack slot counts per main format
  function automatic logic [23:0] main_alloc(input logic [3:0] fmt);
    case (fmt)
      4'h0: main_alloc = {6'h06, 6'h00, 6'h30, 6'h04};
      4'h1: main_alloc = {6'h0a, 6'h00, 6'h28, 6'h08};
      4'h2: main_alloc = {6'h0e, 6'h00, 6'h28, 6'h04};
      4'h3: main_alloc = {6'h12, 6'h00, 6'h20, 6'h08};
      4'h4: main_alloc = {6'h06, 6'h0c, 6'h20, 6'h08};
      4'h5: main_alloc = {6'h0a, 6'h08, 6'h20, 6'h08};
      4'h6: main_alloc = {6'h0e, 6'h04, 6'h20, 6'h08};
      4'h7: main_alloc = {6'h11, 6'h01, 6'h20, 6'h08};
      default: main_alloc = 24'h000000;
    endcase
  endfunction
  // relay other-dl count: 1, 5, 9, 13, 17
  function automatic logic [5:0] relay_other(input logic [3:0] fmt);
    relay_other = {fmt, 2'h0} + 6'h01;
  endfunction
endpackage

// [src/frame_format_decode.sv]
`timescale 1ns/1ps
`default_nettype none
module frame_format_decode (
  // position and formats
  input wire logic [5:0] slot_in,
  input wire logic [3:0] fmt_main_in,
  input wire logic [3:0] fmt_relay_in,
  // decoded subframe
  output sched_pkg::sf_info_t info_out
);
  logic [23:0] al;
  logic [5:0] b_dl;
  logic [5:0] b_nz;
  logic [5:0] b_ud;
  logic [5:0] b_ua;
  logic [5:0] r_dl;
  logic [5:0] r_end;
  // ==================================================
  // subframe boundaries
  assign al = sched_pkg::main_alloc(fmt_main_in);
  assign b_dl = sched_pkg::MAIN_SYNC + al[23:18];
  assign b_nz = b_dl + al[17:12];
  assign b_ud = b_nz + al[11:6];
  assign b_ua = b_ud + al[5:0];
  // relay subframe anchored whatever the format
  assign r_dl = sched_pkg::RELAY_START + sched_pkg::RELAY_SYNC
    + sched_pkg::relay_other(fmt_relay_in);
  assign r_end = r_dl + sched_pkg::RELAY_UL;
  // ==================================================
  // classify the slot
  always_comb begin
    info_out = '0;
    info_out.main_ok = fmt_main_in < sched_pkg::MAIN_FMT_CNT;
    info_out.relay_ok = fmt_relay_in < sched_pkg::RELAY_FMT_CNT;
    info_out.reserved = slot_in == sched_pkg::RESERVED_SLOT;
    // sync slot belongs to the downlink subframe
    if (slot_in < b_dl) begin
      info_out.main_sf = sched_pkg::SF_DL;
      info_out.main_first = slot_in == 6'h00;
    end else if (slot_in < b_nz) begin
      info_out.main_sf = sched_pkg::SF_NOISE;
      info_out.main_first = slot_in == b_dl;
    end else if (slot_in < b_ud) begin
      info_out.main_sf = sched_pkg::SF_ULD;
      info_out.main_first = slot_in == b_nz;
    end else if (slot_in < b_ua) begin
      info_out.main_sf = sched_pkg::SF_ULA;
      info_out.main_first = slot_in == b_ud;
    end
    if (slot_in >= sched_pkg::RELAY_START && slot_in < r_dl) begin
      info_out.relay_sf = sched_pkg::SF_RDL;
      info_out.relay_first = slot_in == sched_pkg::RELAY_START;
    end else if (slot_in >= r_dl && slot_in < r_end) begin
      info_out.relay_sf = sched_pkg::SF_RUL;
      info_out.relay_first = slot_in == r_dl;
    end
  end
endmodule
`default_nettype wire

// [src/frame_slot_scheduler.sv]
`timescale 1ns/1ps
`default_nettype none
module frame_slot_scheduler #(
  parameter int SLOT_CYC = sched_pkg::SLOT_CYC,
  parameter int ACTIVE_CYC = sched_pkg::ACTIVE_CYC,
  parameter int CW = 27
) (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  // frame control
  input wire logic REF_SYNC_IN,
  input wire logic [1:0] OFFSET_IN,
  input wire logic [3:0] FMT_MAIN_IN,
  input wire logic [3:0] FMT_RELAY_IN,
  // burst request
  input wire logic TX_REQ_IN,
  input wire sched_pkg::txreq_t TX_REQ_DATA_IN,
  output logic TX_REQ_READY_OUT,
  // power management
  input wire logic CONNECTED_IN,
  input wire logic [1:0] CLASS_IN,
  input wire logic RX_DONE_IN,
  input wire logic KEEP_ACTIVE_IN,
  input wire logic RELAY_BUSY_IN,
  input wire logic RESYNC_DONE_IN,
  // timing status
  output logic [5:0] SLOT_OUT,
  output logic [5:0] FRAME_OUT,
  output logic SUPER_OUT,
  output logic GUARD_OUT,
  output sched_pkg::sf_info_t SF_INFO_OUT,
  // radio control
  output logic TX_ON_OUT,
  output logic PWR_LOW_OUT,
  output logic RX_ON_OUT,
  output logic SLEEP_OUT
);
  // ==================================================
  // elaboration check
  if (ACTIVE_CYC < 1 || ACTIVE_CYC >= SLOT_CYC || SLOT_CYC > (1 << CW) || CW > 31) begin : g_chk
    $error("slot timing parameters out of range");
  end

  localparam int SLOTS_PER_FRAME_C = sched_pkg::SLOTS_PER_FRAME;

  logic rs1_r;
  logic rst_n;
  logic [CW-1:0] cyc_r;
  logic [CW-1:0] cyc_nxt;
  logic slot_end;
  logic frame_end;
  logic [5:0] slot_r;
  logic [5:0] frame_r;
  logic super_r;
  logic [3:0] fmt_main_r;
  logic [3:0] fmt_relay_r;
  sched_pkg::sf_info_t info;
  sched_pkg::txreq_t pend_r;
  logic cont_r;
  logic in_burst_r;
  logic in_burst_nxt;
  logic tx_on_r;
  logic kind_ok;
  logic sf_first;
  logic start_ok;
  logic tx_allowed;
  logic rx_done_r;
  logic idle_ok;
  logic [5:0] hold_r;
  sched_pkg::pwr_t st_r;
  sched_pkg::pwr_t st_nxt;

  // ==================================================
  // reset release through two flops
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rs1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rst_n <= rs1_r;
    end
  end

  // ==================================================
  // slot timer
  assign slot_end = cyc_r == CW'(SLOT_CYC - 1);
  assign frame_end = slot_end && slot_r == sched_pkg::LAST_SLOT;
  assign cyc_nxt = (slot_end || REF_SYNC_IN) ? '0 : cyc_r + CW'(1);
  assign GUARD_OUT = cyc_r >= CW'(ACTIVE_CYC);

  // cycle count within the slot; reference pulse restarts it
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      cyc_r <= '0;
    end else begin
      cyc_r <= cyc_nxt;
    end
  end

  // slot and frame counters; reference loads the offset position
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      slot_r <= 6'h00;
      frame_r <= 6'h00;
      super_r <= 1'b0;
    end else begin
      super_r <= 1'b0;
      if (REF_SYNC_IN) begin
        // a delayed cell is still in the previous frame at the reference
        case (OFFSET_IN)
          sched_pkg::OFS_20: begin
            slot_r <= 6'(SLOTS_PER_FRAME_C) - sched_pkg::OFS_20_SLOTS;
            frame_r <= sched_pkg::LAST_FRAME;
          end
          sched_pkg::OFS_40: begin
            slot_r <= 6'(SLOTS_PER_FRAME_C) - sched_pkg::OFS_40_SLOTS;
            frame_r <= sched_pkg::LAST_FRAME;
          end
          default: begin
            slot_r <= 6'h00;
            frame_r <= 6'h00;
            super_r <= 1'b1;
          end
        endcase
      end else if (slot_end) begin
        if (slot_r == sched_pkg::LAST_SLOT) begin
          slot_r <= 6'h00;
          frame_r <= frame_r + 6'h01;
          super_r <= frame_r == sched_pkg::LAST_FRAME;
        end else begin
          slot_r <= slot_r + 6'h01;
        end
      end
    end
  end

  // formats in force are taken at the frame boundary or on a reference pulse
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      fmt_main_r <= 4'h0;
      fmt_relay_r <= 4'h0;
    end else if (frame_end || REF_SYNC_IN) begin
      fmt_main_r <= FMT_MAIN_IN;
      fmt_relay_r <= FMT_RELAY_IN;
    end
  end

  frame_format_decode u_dec (
    .slot_in(slot_r),
    .fmt_main_in(fmt_main_r),
    .fmt_relay_in(fmt_relay_r),
    .info_out(info)
  );

  // ==================================================
  // burst engine
  assign TX_REQ_READY_OUT = pend_r.units == 8'h00;
  // relay kinds follow the relay format, the rest the main one
  always_comb begin
    if (pend_r.sf == sched_pkg::SF_RDL || pend_r.sf == sched_pkg::SF_RUL) begin
      kind_ok = info.relay_sf == pend_r.sf && info.relay_ok;
      sf_first = info.relay_first;
    end else begin
      kind_ok = info.main_sf == pend_r.sf && info.main_ok;
      sf_first = info.main_first;
    end
  end
  // a burst opens only on a subframe's first slot or continues unbroken
  assign start_ok = pend_r.units != 8'h00 && kind_ok && !info.reserved
    && tx_allowed && (sf_first || cont_r);
  assign in_burst_nxt = slot_end ? 1'b0 : (cyc_r == '0 ? start_ok : in_burst_r);

  // pending units: taken when idle, one spent per burst slot
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= '0;
    end else if (TX_REQ_IN && TX_REQ_READY_OUT) begin
      pend_r <= TX_REQ_DATA_IN;
    end else if (slot_end && in_burst_r) begin
      pend_r.units <= pend_r.units - 8'h01;
    end
  end

  // continuation survives only between back-to-back burst slots
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      cont_r <= 1'b0;
    end else if (slot_end) begin
      cont_r <= in_burst_r && pend_r.units != 8'h01;
    end
  end

  // carrier keyed only in the active part; guard keeps power down
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      in_burst_r <= 1'b0;
      tx_on_r <= 1'b0;
    end else begin
      in_burst_r <= in_burst_nxt;
      tx_on_r <= in_burst_nxt && cyc_nxt < CW'(ACTIVE_CYC);
    end
  end

  // ==================================================
  // battery saving
  assign tx_allowed = st_r == sched_pkg::ST_AWAKE || st_r == sched_pkg::ST_HOLD;
  assign idle_ok = pend_r.units == 8'h00 && !RELAY_BUSY_IN && !KEEP_ACTIVE_IN
    && rx_done_r;

  // served-this-frame flag; a done in the boundary cycle wins over clear
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      rx_done_r <= 1'b0;
    end else if (RX_DONE_IN) begin
      rx_done_r <= 1'b1;
    end else if (frame_end) begin
      rx_done_r <= 1'b0;
    end
  end

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      sched_pkg::ST_AWAKE: begin
        if (CONNECTED_IN && CLASS_IN != sched_pkg::CLS_NONE && idle_ok) begin
          st_nxt = sched_pkg::ST_SLEEP;
        end
      end
      sched_pkg::ST_SLEEP: begin
        if (!CONNECTED_IN || CLASS_IN == sched_pkg::CLS_NONE) begin
          st_nxt = sched_pkg::ST_AWAKE;
        end else if (CLASS_IN == sched_pkg::CLS_DORMANT) begin
          if (pend_r.units != 8'h00) begin
            st_nxt = sched_pkg::ST_RESYNC;
          end
        end else if (frame_end) begin
          // wake right at the boundary so the first slot is not missed
          if (CLASS_IN == sched_pkg::CLS_LISTEN || frame_r == sched_pkg::LAST_FRAME
              || KEEP_ACTIVE_IN) begin
            st_nxt = sched_pkg::ST_AWAKE;
          end
        end
      end
      sched_pkg::ST_RESYNC: begin
        if (RESYNC_DONE_IN) begin
          st_nxt = sched_pkg::ST_HOLD;
        end
      end
      sched_pkg::ST_HOLD: begin
        if (frame_end && hold_r == sched_pkg::LAST_FRAME) begin
          st_nxt = sched_pkg::ST_AWAKE;
        end
      end
      default: st_nxt = sched_pkg::ST_AWAKE;
    endcase
  end

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= sched_pkg::ST_AWAKE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // frames spent in hold, the initiating frame counted as the first
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      hold_r <= 6'h00;
    end else if (st_r != sched_pkg::ST_HOLD) begin
      hold_r <= 6'h00;
    end else if (frame_end) begin
      hold_r <= hold_r + 6'h01;
    end
  end

  // ==================================================
  // outputs
  assign SLOT_OUT = slot_r;
  assign FRAME_OUT = frame_r;
  assign SUPER_OUT = super_r;
  assign SF_INFO_OUT = info;
  assign TX_ON_OUT = tx_on_r;
  assign PWR_LOW_OUT = !tx_on_r;
  assign RX_ON_OUT = st_r != sched_pkg::ST_SLEEP;
  assign SLEEP_OUT = st_r == sched_pkg::ST_SLEEP;

  // ==================================================
  // assertions
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!rst_n);

  AST_TX_ACTIVE: assert property (tx_on_r |-> cyc_r < CW'(ACTIVE_CYC))
    else $error("carrier on in guard");
  AST_NO_SLOT55: assert property (tx_on_r |-> slot_r != sched_pkg::RESERVED_SLOT)
    else $error("transmit in reserved slot");
  AST_SLOT_WRAP: assert property (frame_end && !REF_SYNC_IN |=> slot_r == 6'h00
    && frame_r == 6'($past(frame_r) + 6'h01))
    else $error("slot wrap wrong");
  AST_SUPER: assert property (frame_end && frame_r == sched_pkg::LAST_FRAME
    && !REF_SYNC_IN |=> super_r && frame_r == 6'h00)
    else $error("superframe boundary missed");
  AST_VALID_FMT: assert property (tx_on_r |-> kind_ok)
    else $error("transmit with reserved format");
  AST_PWR_DROP: assert property (slot_end && in_burst_r |-> !tx_on_r [*2])
    else $error("power not lowered between bursts");
  AST_STOP_DONE: assert property (pend_r.units == 8'h00 && !TX_REQ_IN |=> !in_burst_r)
    else $error("burst outlived its units");
  AST_OPEN_FIRST: assert property ($rose(in_burst_r) && !cont_r |-> $past(sf_first))
    else $error("burst opened mid subframe");
  AST_RELAY_19: assert property (slot_r == sched_pkg::RELAY_START && info.relay_ok
    |-> info.relay_sf == sched_pkg::SF_RDL && info.relay_first)
    else $error("relay subframe misplaced");
  AST_SLEEP_CONN: assert property ($rose(SLEEP_OUT) |-> $past(CONNECTED_IN))
    else $error("sleep without connection");
  AST_RESYNC_QUIET: assert property (st_r == sched_pkg::ST_RESYNC |-> !tx_on_r)
    else $error("uplink before resync");

  COV_BURST_END: cover property (in_burst_r && pend_r.units == 8'h01 && slot_end);
  COV_SUPER: cover property (super_r);
  COV_HOLD: cover property (st_r == sched_pkg::ST_RESYNC ##1 st_r == sched_pkg::ST_HOLD);
  COV_SLEEP: cover property ($rose(SLEEP_OUT));
endmodule
`default_nettype wire

// [tb/radio_peer.sv]
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// far-side radio: reference sync, served notice, resync
module radio_peer (
  // clock and observed state
  input wire logic clk_in,
  input wire logic rx_on_in,
  input wire logic [5:0] slot_in,
  // drives toward the scheduler
  output logic ref_sync_out,
  output logic [1:0] offset_out,
  output logic rx_done_out,
  output logic resync_done_out
);
  logic serve = 1'b0;
  logic done_r = 1'b0;
  // idle levels at time zero
  initial begin
    ref_sync_out = 1'b0;
    offset_out = 2'h0;
    resync_done_out = 1'b0;
  end
  // zero alignment error; offset travels with the pulse
  task automatic sync(input logic [1:0] ofs);
    @(negedge clk_in);
    ref_sync_out = 1'b1;
    offset_out = ofs;
    @(negedge clk_in);
    ref_sync_out = 1'b0;
  endtask
  // one-cycle notice that full resync is done
  task automatic resync();
    @(negedge clk_in);
    resync_done_out = 1'b1;
    @(negedge clk_in);
    resync_done_out = 1'b0;
  endtask
  // served notice in slot 2, only heard by a node whose receiver is on
  always @(negedge clk_in) begin
    done_r <= serve && rx_on_in && slot_in == 6'h02;
  end
  assign rx_done_out = done_r;
endmodule
`default_nettype wire

// [tb/frame_slot_scheduler_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module frame_slot_scheduler_tb;
  // ==================================================
  // signals
  // slot and active part scaled down in the same 400:384 ratio
  localparam int SC = 25;
  localparam int AC = 24;
  logic clk;
  logic tx_d = 1'b0;
  logic nrst, req, conn, keep, busy;
  logic rsync, rxd, rsd, ready, sup, guard, tx_on, pwr_low, rx_on, sleep;
  logic [1:0] ofs;
  logic [1:0] cls;
  logic [3:0] fm, fr;
  logic [5:0] slot, frame;
  sched_pkg::txreq_t rd;
  sched_pkg::sf_info_t info;
  logic [5:0] txq[$];
  logic [5:0] expq[$];
  int miscompares = 0;
  int n_tests = 0;
  int mt[8][4] = '{'{6, 0, 48, 4}, '{10, 0, 40, 8}, '{14, 0, 40, 4}, '{18, 0, 32, 8},
    '{6, 12, 32, 8}, '{10, 8, 32, 8}, '{14, 4, 32, 8}, '{17, 1, 32, 8}};
  // ==================================================
  // instances; short slot keeps the run small
  frame_slot_scheduler #(.SLOT_CYC(SC), .ACTIVE_CYC(AC)) frame_slot_scheduler_i (
    .CLK_IN(clk), .NRST_IN(nrst), .REF_SYNC_IN(rsync), .OFFSET_IN(ofs),
    .FMT_MAIN_IN(fm), .FMT_RELAY_IN(fr), .TX_REQ_IN(req), .TX_REQ_DATA_IN(rd),
    .TX_REQ_READY_OUT(ready), .CONNECTED_IN(conn), .CLASS_IN(cls), .RX_DONE_IN(rxd),
    .KEEP_ACTIVE_IN(keep), .RELAY_BUSY_IN(busy), .RESYNC_DONE_IN(rsd), .SLOT_OUT(slot),
    .FRAME_OUT(frame), .SUPER_OUT(sup), .GUARD_OUT(guard), .SF_INFO_OUT(info),
    .TX_ON_OUT(tx_on), .PWR_LOW_OUT(pwr_low), .RX_ON_OUT(rx_on), .SLEEP_OUT(sleep));
  radio_peer radio_peer_i (
    .clk_in(clk), .rx_on_in(rx_on), .slot_in(slot), .ref_sync_out(rsync),
    .offset_out(ofs), .rx_done_out(rxd), .resync_done_out(rsd));
  // 250 MHz
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ==================================================
  // checking tasks
  task automatic err(input string m);
    miscompares++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic chk1(input logic g, input logic e, input string m);
    n_tests++;
    if (g !== e) err(m);
  endtask
  task automatic chk6(input logic [5:0] g, input logic [5:0] e, input string m);
    n_tests++;
    if (g !== e) err(m);
  endtask
  task automatic chksf(input sched_pkg::sub_t g, input sched_pkg::sub_t e, input string m);
    n_tests++;
    if (g !== e) err(m);
  endtask
  // burst slot list against expectation
  task automatic chkq(input string m);
    n_tests++;
    if (txq.size() != expq.size()) err(m);
    else foreach (expq[i]) if (txq[i] !== expq[i]) err(m);
    expq.delete();
  endtask
  task automatic run(input int f, input int n);
    for (int i = 0; i < n; i++) expq.push_back(6'(f + i));
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ==================================================
  // driving tasks
  task automatic issue(input sched_pkg::sub_t sf, input logic [7:0] n);
    txq.delete();
    @(negedge clk);
    req = 1'b1;
    rd.sf = sf;
    rd.units = n;
    @(negedge clk);
    req = 1'b0;
  endtask
  task automatic wait_ready(input int lim);
    int i;
    for (i = 0; i < lim && ready !== 1'b1; i++) @(negedge clk);
    if (i == lim) err("burst never finished");
  endtask
  task automatic wait_slot(input logic [5:0] s);
    int i;
    for (i = 0; i < 70 * SC && slot !== s; i++) @(negedge clk);
    if (i == 70 * SC) err("slot never reached");
  endtask
  // every slot of each format through the running design, one frame per format
  task automatic decode_all();
    int b0, b1, b2, b3, r0;
    sched_pkg::sub_t em, er;
    for (int f = 0; f < 9; f++) begin
      fm = 4'(f);
      fr = 4'(f);
      radio_peer_i.sync(2'h0);
      for (int s = 0; s < 60; s++) begin
        chk6(slot, 6'(s), "sweep slot");
        chk1(info.reserved, s == 55, "reserved slot flag");
        chk1(info.main_ok, f < 8, "main format valid");
        chk1(info.relay_ok, f < 5, "relay format valid");
        if (f < 8 && s != 55) begin
          b0 = 1 + mt[f][0];
          b1 = b0 + mt[f][1];
          b2 = b1 + mt[f][2];
          b3 = b2 + mt[f][3];
          em = s < b0 ? sched_pkg::SF_DL : s < b1 ? sched_pkg::SF_NOISE :
            s < b2 ? sched_pkg::SF_ULD : s < b3 ? sched_pkg::SF_ULA : sched_pkg::SF_NONE;
          chksf(info.main_sf, em, "main subframe");
          if (em != sched_pkg::SF_NONE)
            chk1(info.main_first, s == 0 || s == b0 || s == b1 || s == b2, "main first");
        end
        if (f < 5 && s != 55) begin
          r0 = 21 + 4 * f;
          er = s < 19 ? sched_pkg::SF_NONE : s < r0 ? sched_pkg::SF_RDL :
            s < r0 + 5 ? sched_pkg::SF_RUL : sched_pkg::SF_NONE;
          chksf(info.relay_sf, er, "relay subframe");
          if (er != sched_pkg::SF_NONE)
            chk1(info.relay_first, s == 19 || s == r0, "relay first");
        end
        repeat (SC) @(negedge clk);
      end
    end
    fm = 4'h0;
    fr = 4'h0;
  endtask
  // records the slot each time the carrier comes on, once per burst slot; sampled mid-cycle so outputs have settled
  always @(negedge clk) begin
    tx_d <= tx_on;
    if (tx_on === 1'b1 && tx_d !== 1'b1) txq.push_back(slot);
    if (tx_on === 1'b1 && (guard === 1'b1 || slot === 6'h37)) err("carrier on in guard");
  end
  // watchdog sized well above the expected run length
  initial begin
    repeat (90000) @(posedge clk);
    err("watchdog expired");
    test_done();
  end
  // ==================================================
  // main sequence
  initial begin
    {nrst, req, conn, keep, busy, cls, fm, fr} = '0;
    rd = '0;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    chk6(frame, 6'h00, "frame at reset");
    chk1(pwr_low, 1'b1, "power low at reset");
    chk1(ready, 1'b1, "ready at reset");
    $display("test reset done");
    decode_all();
    $display("test decode done");
    radio_peer_i.sync(2'h0);
    chk1(sup, 1'b1, "superframe pulse");
    chk6(slot, 6'h00, "slot after sync");
    repeat (AC - 1) @(negedge clk);
    chk1(guard, 1'b0, "guard too early");
    @(negedge clk);
    chk1(guard, 1'b1, "guard missing");
    chk1(sup, 1'b0, "pulse too long");
    repeat (SC - AC) @(negedge clk);
    chk6(slot, 6'h01, "slot length");
    radio_peer_i.sync(2'h2);
    chk6(slot, 6'h14, "offset 40 slot");
    radio_peer_i.sync(2'h1);
    chk6(slot, 6'h28, "offset 20 slot");
    chk6(frame, 6'h3f, "offset frame");
    repeat (20 * SC - 1) @(negedge clk);
    chk6(slot, 6'h3b, "last slot");
    @(negedge clk);
    chk6(frame, 6'h00, "frame wrap");
    chk1(sup, 1'b1, "wrap pulse");
    $display("test timing done");
    radio_peer_i.sync(2'h0);
    issue(sched_pkg::SF_ULD, 8'h02);
    wait_ready(10 * SC);
    run(7, 2);
    chkq("uplink burst");
    issue(sched_pkg::SF_DL, 8'h09);
    wait_ready(130 * SC);
    run(0, 7);
    run(0, 2);
    chkq("downlink carry over");
    issue(sched_pkg::SF_RUL, 8'h05);
    wait_ready(60 * SC);
    run(21, 5);
    chkq("relay burst");
    fm = 4'h8;
    radio_peer_i.sync(2'h0);
    issue(sched_pkg::SF_ULD, 8'h01);
    fm = 4'h0;
    wait_slot(6'h1e);
    chk1(ready, 1'b0, "pending under bad format");
    chkq("burst under bad format");
    wait_ready(70 * SC);
    run(7, 1);
    chkq("burst after format fixed");
    $display("test bursts done");
    radio_peer_i.serve = 1'b1;
    cls = 2'h1;
    radio_peer_i.sync(2'h0);
    wait_slot(6'h03);
    chk1(sleep, 1'b0, "sleep unconnected");
    conn = 1'b1;
    busy = 1'b1;
    radio_peer_i.sync(2'h0);
    wait_slot(6'h03);
    chk1(sleep, 1'b0, "sleep while relay busy");
    busy = 1'b0;
    repeat (3) @(negedge clk);
    chk1(sleep, 1'b1, "listener sleeps");
    chk1(rx_on, 1'b0, "receiver on in sleep");
    wait_slot(6'h00);
    chk1(sleep, 1'b0, "listener wakes");
    cls = 2'h2;
    keep = 1'b1;
    radio_peer_i.sync(2'h0);
    wait_slot(6'h03);
    chk1(sleep, 1'b0, "kept awake");
    keep = 1'b0;
    repeat (3) @(negedge clk);
    chk1(sleep, 1'b1, "periodic sleeps");
    wait_slot(6'h00);
    chk1(sleep, 1'b1, "awake outside frame 0");
    cls = 2'h3;
    radio_peer_i.sync(2'h0);
    wait_slot(6'h03);
    chk1(sleep, 1'b1, "dormant sleeps");
    issue(sched_pkg::SF_ULD, 8'h01);
    wait_slot(6'h00);
    wait_slot(6'h14);
    chkq("uplink before resync");
    radio_peer_i.resync();
    wait_ready(70 * SC);
    run(7, 1);
    chkq("uplink after resync");
    wait_slot(6'h1e);
    chk1(sleep, 1'b0, "asleep after dormant send");
    $display("test power done");
    test_done();
  end
endmodule
`default_nettype wire
